// ===== src/ddc_map.svh
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
`define REG_THR_SEL 8'h45
`define REG_PATH_MODE 8'h50
`define REG_DITHER 8'h51
`define REG_FREQ0 8'h52
`define REG_FREQ1 8'h53
`define REG_FREQ2 8'h54
`define REG_FREQ3 8'h55
`define REG_PHASE0 8'h56
`define REG_PHASE1 8'h57
`define REG_SYNC_CTL 8'h58
`define REG_SYNC_MODE 8'h59
`define REG_LL_SEL 8'h5a
`define REG_STATUS 8'h5b
`define RST_PATH_MODE 8'hb0
`define RST_DITHER 8'h06
`define RST_LL_SEL 8'h01
`define PM_LL_BIT 4
`define DITH_AMP_BIT 1
`define DITH_PH_BIT 2
`define SC_NCO_EN 0
`define SC_NCO_EVERY 1
`define SC_FIR_EN 4
`define SC_FIR_EVERY 5
`define SC_ONCO_EN 6
`define SC_ONCO_EVERY 7
`define SM_FALL_BIT 0
`define SM_EDGE_BIT 1
`define NCO_FS4 32'h40000000
`define FD_TH_LOW 14'h1000
`define FD_TH_HIGH 14'h1c00
`define FD_LATENCY 4
`define FIR_LL_SHIFT 18
`define FIR_HP_SHIFT 21
`define HP_TAPS 47
`define LFSR_SEED 16'hace1
`endif

// ===== src/ddc_pkg.sv
package ddc_pkg;
   typedef struct packed {
      logic signed [15:0] a;
      logic signed [15:0] b;
   } out_word_t;
   typedef enum logic [1:0] {ROT_0 = 2'h0, ROT_1 = 2'h1, ROT_2 = 2'h3, ROT_3 = 2'h2} rot_t;
endpackage: ddc_pkg

// ===== src/ddc_sym_fir.sv
`include "ddc_map.svh"
module ddc_sym_fir #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic adv,
   input wire logic restart,
   input wire logic ll,
   input wire logic signed [W-1:0] din,
   output logic signed [W-1:0] dout
);
   localparam int CW = 21;
   localparam int AW = W + CW + 7;
   localparam logic signed [CW-1:0] LL_C [11] = '{21'sd1056, 21'sd1360, -21'sd1248, -21'sd5248, 21'sd1952,
      21'sd13184, -21'sd2528, -21'sd26752, -21'sd2752, 21'sd88576, 21'sd109504};
   localparam logic signed [CW-1:0] HP_C [24] = '{-21'sd140, -21'sd1016, -21'sd2536, -21'sd2028, 21'sd2473,
      21'sd5375, -21'sd1015, -21'sd9042, -21'sd1192, 21'sd14900, 21'sd6784, -21'sd21768, -21'sd16887,
      21'sd28794, 21'sd32572, -21'sd36526, -21'sd58488, 21'sd43620, 21'sd103472, -21'sd48652,
      -21'sd198548, 21'sd53040, 21'sd641040, 21'sd961682};
   logic signed [W-1:0] taps_q [`HP_TAPS];
   logic signed [AW-1:0] acc;

   // Delay line, cleared on a restart so the filter starts from phase zero
   always_ff @(posedge clk) begin
      if (srst || restart) begin
         for (int n = 0; n < `HP_TAPS; n++) begin
            taps_q[n] <= '0;
         end
      end else if (adv) begin
         taps_q[0] <= din;
         for (int n = 1; n < `HP_TAPS; n++) begin
            taps_q[n] <= taps_q[n-1];
         end
      end
   end
   property p_restart_clear;
      @(posedge clk) disable iff (srst) restart |=> taps_q[0] == '0 && taps_q[`HP_TAPS-1] == '0;
   endproperty
   a_restart_clear: assert property (p_restart_clear) else $error("Filter delay line not cleared on sync");

   // Folded symmetric sum of products
   always_comb begin
      acc = '0;
      for (int k = 0; k < 24; k++) begin
         if (ll && k < 10) begin
            acc = acc + (AW'(taps_q[k]) + AW'(taps_q[20-k])) * AW'(LL_C[k]);
         end else if (ll && k == 10) begin
            acc = acc + AW'(taps_q[10]) * AW'(LL_C[10]);
         end else if (!ll && k < 23) begin
            acc = acc + (AW'(taps_q[k]) + AW'(taps_q[46-k])) * AW'(HP_C[k]);
         end else if (!ll) begin
            acc = acc + AW'(taps_q[23]) * AW'(HP_C[23]);
         end
      end
   end

   // One output per accepted sample, scaled per mode
   always_ff @(posedge clk) begin
      if (srst) begin
         dout <= '0;
      end else if (adv) begin
         dout <= ll ? acc[`FIR_LL_SHIFT +: W] : acc[`FIR_HP_SHIFT +: W];
      end
   end
endmodule: ddc_sym_fir

// ===== src/ddc_skid2.sv
module ddc_skid2 #(
   parameter int W = 32,
   parameter int D = 2
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = cnt_q != (PW+1)'(D);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == PW'(D - 1)) ? '0 : PW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == PW'(D - 1)) ? '0 : PW'(rd_q + 1'b1);
         end
         cnt_q <= (PW+1)'(cnt_q + (PW+1)'(push) - (PW+1)'(pop));
      end
   end
endmodule: ddc_skid2

// ===== src/ddc_fir_output_nco_path.sv
`include "ddc_map.svh"
module ddc_fir_output_nco_path (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic signed [13:0] ADC_A,
   input wire logic signed [13:0] ADC_B,
   input wire logic SYNC,
   input wire logic REG_WE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic ADC_READY,
   output logic OUT_VALID,
   input wire logic OUT_READY,
   output ddc_pkg::out_word_t OUT_DATA,
   output logic [1:0] THRESHOLD_ALARM_OUTPUT
);
   localparam logic [15:0] QW [16] = '{16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fc, 16'h3c57,
      16'h471d, 16'h5134, 16'h5a82, 16'h62f2, 16'h6a6e, 16'h70e3, 16'h7641, 16'h7a7d, 16'h7d8a, 16'h7f62};

   logic [7:0] thr_sel_q;
   logic [7:0] path_mode_q;
   logic [7:0] dither_q;
   logic [31:0] freq_q;
   logic [15:0] phase_off_q;
   logic [7:0] sync_ctl_q;
   logic [7:0] sync_mode_q;
   logic [7:0] ll_sel_q;
   logic sync_m_q;
   logic sync_s_q;
   logic sync_p_q;
   logic sync_evt;
   logic [2:0] armed_q;
   logic [2:0] sync_en;
   logic [2:0] sync_every;
   logic [2:0] restart;
   logic sc_write;
   logic ll_mode;
   logic fixed_nco;
   logic adv;
   logic [31:0] acc_q;
   logic [31:0] freq_eff;
   logic [31:0] ph_dith;
   logic [5:0] ph_idx;
   logic [15:0] lfsr_q;
   logic signed [14:0] amp_sin;
   logic signed [14:0] amp_cos;
   logic signed [13:0] adc [2];
   logic signed [15:0] fir_out [4];
   logic signed [15:0] out_s [2];
   logic fd_raw [2];
   logic [1:0] fd_pipe_q [`FD_LATENCY];
   logic [13:0] fd_th;
   ddc_pkg::rot_t rot_q;
   ddc_pkg::rot_t rot_next;
   ddc_pkg::out_word_t out_w;
   logic [31:0] buf_out;
   function automatic logic signed [15:0] sin_lut(input logic [5:0] p);
      logic [3:0] idx;
      logic [15:0] mag;
      idx = p[4] ? 4'(5'h10 - {1'b0, p[3:0]}) : p[3:0];
      mag = (p[4] && p[3:0] == 4'h0) ? 16'h7fff : QW[idx];
      sin_lut = p[5] ? -mag : mag;
   endfunction: sin_lut
   function automatic logic signed [14:0] amp_round(input logic signed [15:0] v, input logic [1:0] d);
      logic [16:0] s;
      s = {v[15], v} + {15'h0000, d};
      amp_round = s[16:2];
   endfunction: amp_round
   // Register port writes
   always_ff @(posedge CLK) begin
      if (SRST) begin
         thr_sel_q <= 8'h00;
         path_mode_q <= `RST_PATH_MODE;
         dither_q <= `RST_DITHER;
         freq_q <= `NCO_FS4;
         phase_off_q <= 16'h0000;
         sync_ctl_q <= 8'h00;
         sync_mode_q <= 8'h00;
         ll_sel_q <= `RST_LL_SEL;
      end else if (REG_WE) begin
         case (REG_ADDR)
            `REG_THR_SEL: thr_sel_q <= REG_WDATA;
            `REG_PATH_MODE: path_mode_q <= REG_WDATA;
            `REG_DITHER: dither_q <= REG_WDATA;
            `REG_FREQ0: freq_q[7:0] <= REG_WDATA;
            `REG_FREQ1: freq_q[15:8] <= REG_WDATA;
            `REG_FREQ2: freq_q[23:16] <= REG_WDATA;
            `REG_FREQ3: freq_q[31:24] <= REG_WDATA;
            `REG_PHASE0: phase_off_q[7:0] <= REG_WDATA;
            `REG_PHASE1: phase_off_q[15:8] <= REG_WDATA;
            `REG_SYNC_CTL: sync_ctl_q <= REG_WDATA;
            `REG_SYNC_MODE: sync_mode_q <= REG_WDATA;
            `REG_LL_SEL: ll_sel_q <= REG_WDATA;
            default: ;
         endcase
      end
   end

   // Register port reads, one cycle after the address
   always_ff @(posedge CLK) begin
      if (SRST) begin
         REG_RDATA <= 8'h00;
      end else begin
         case (REG_ADDR)
            `REG_THR_SEL: REG_RDATA <= thr_sel_q;
            `REG_PATH_MODE: REG_RDATA <= path_mode_q;
            `REG_DITHER: REG_RDATA <= dither_q;
            `REG_FREQ0: REG_RDATA <= freq_q[7:0];
            `REG_FREQ1: REG_RDATA <= freq_q[15:8];
            `REG_FREQ2: REG_RDATA <= freq_q[23:16];
            `REG_FREQ3: REG_RDATA <= freq_q[31:24];
            `REG_PHASE0: REG_RDATA <= phase_off_q[7:0];
            `REG_PHASE1: REG_RDATA <= phase_off_q[15:8];
            `REG_SYNC_CTL: REG_RDATA <= sync_ctl_q;
            `REG_SYNC_MODE: REG_RDATA <= sync_mode_q;
            `REG_LL_SEL: REG_RDATA <= ll_sel_q;
            `REG_STATUS: REG_RDATA <= {3'h0, armed_q, THRESHOLD_ALARM_OUTPUT};
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end
   // Sync pin retiming and event selection
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sync_m_q <= 1'b0;
         sync_s_q <= 1'b0;
         sync_p_q <= 1'b0;
      end else begin
         sync_m_q <= SYNC;
         sync_s_q <= sync_m_q;
         sync_p_q <= sync_s_q;
      end
   end
   assign sync_evt = !sync_mode_q[`SM_EDGE_BIT] ? sync_s_q :
      (sync_mode_q[`SM_FALL_BIT] ? (sync_p_q & ~sync_s_q) : (~sync_p_q & sync_s_q));
   assign sc_write = REG_WE && REG_ADDR == `REG_SYNC_CTL;
   assign sync_en = {sync_ctl_q[`SC_ONCO_EN], sync_ctl_q[`SC_FIR_EN], sync_ctl_q[`SC_NCO_EN]};
   assign sync_every = {sync_ctl_q[`SC_ONCO_EVERY], sync_ctl_q[`SC_FIR_EVERY], sync_ctl_q[`SC_NCO_EVERY]};
   assign restart = {3{sync_evt}} & sync_en & (sync_every | armed_q);
   // One-shot arming; a write in the same cycle as a sync re-arms
   always_ff @(posedge CLK) begin
      if (SRST) begin
         armed_q <= 3'h0;
      end else if (sc_write) begin
         armed_q <= 3'h7;
      end else begin
         armed_q <= armed_q & ~(restart & ~sync_every);
      end
   end
   // Tuning oscillator with dither
   assign ll_mode = path_mode_q[`PM_LL_BIT];
   assign fixed_nco = ll_mode & ll_sel_q[0];
   assign freq_eff = fixed_nco ? `NCO_FS4 : freq_q;
   assign ph_dith = acc_q + (dither_q[`DITH_PH_BIT] ? {6'h00, lfsr_q, 10'h000} : 32'h00000000);
   assign ph_idx = ph_dith[31:26];
   assign amp_sin = amp_round(sin_lut(ph_idx), dither_q[`DITH_AMP_BIT] ? lfsr_q[1:0] : 2'h0);
   assign amp_cos = amp_round(sin_lut(6'(ph_idx + 6'h10)), dither_q[`DITH_AMP_BIT] ? lfsr_q[3:2] : 2'h0);
   always_ff @(posedge CLK) begin
      if (SRST) begin
         lfsr_q <= `LFSR_SEED;
      end else begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end
   always_ff @(posedge CLK) begin
      if (SRST) begin
         acc_q <= 32'h00000000;
      end else if (restart[0]) begin
         acc_q <= {phase_off_q, 16'h0000};
      end else if (adv) begin
         acc_q <= acc_q + freq_eff;
      end
   end
   // Output oscillator phase
   always_comb begin
      unique case (rot_q)
         ddc_pkg::ROT_0: rot_next = ddc_pkg::ROT_1;
         ddc_pkg::ROT_1: rot_next = ddc_pkg::ROT_2;
         ddc_pkg::ROT_2: rot_next = ddc_pkg::ROT_3;
         ddc_pkg::ROT_3: rot_next = ddc_pkg::ROT_0;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (SRST || restart[2]) begin
         rot_q <= ddc_pkg::ROT_0;
      end else if (adv) begin
         rot_q <= rot_next;
      end
   end
   assign adc[0] = ADC_A;
   assign adc[1] = ADC_B;
   assign fd_th = thr_sel_q[0] ? `FD_TH_HIGH : `FD_TH_LOW;
   for (genvar c = 0; c < 2; c++) begin: g_chan
      logic signed [28:0] prod_i;
      logic signed [28:0] prod_q;
      logic signed [15:0] mix_i_q;
      logic signed [15:0] mix_q_q;
      logic signed [15:0] real_v;
      logic signed [15:0] out_q;
      logic [13:0] mag;
      assign prod_i = adc[c] * amp_cos;
      assign prod_q = adc[c] * amp_sin;
      assign mag = adc[c][13] ? 14'(-adc[c]) : 14'(adc[c]);
      assign fd_raw[c] = mag > fd_th;
      always_ff @(posedge CLK) begin
         if (SRST) begin
            mix_i_q <= 16'h0000;
            mix_q_q <= 16'h0000;
         end else if (adv) begin
            mix_i_q <= prod_i[28:13];
            mix_q_q <= -prod_q[28:13];
         end
      end
      for (genvar k = 0; k < 2; k++) begin: g_comp
         ddc_sym_fir #(.W(16)) u_fir (
            .clk(CLK),
            .srst(SRST),
            .adv(adv),
            .restart(restart[1]),
            .ll(ll_mode),
            .din(k == 0 ? mix_i_q : mix_q_q),
            .dout(fir_out[2*c+k])
         );
      end
      always_comb begin
         unique case (rot_q)
            ddc_pkg::ROT_0: real_v = fir_out[2*c];
            ddc_pkg::ROT_1: real_v = -fir_out[2*c+1];
            ddc_pkg::ROT_2: real_v = -fir_out[2*c];
            ddc_pkg::ROT_3: real_v = fir_out[2*c+1];
         endcase
      end
      always_ff @(posedge CLK) begin
         if (SRST) begin
            out_q <= 16'h0000;
         end else if (adv) begin
            out_q <= real_v;
         end
      end
      assign out_s[c] = out_q;
   end
   // Fast detect pipeline
   always_ff @(posedge CLK) begin
      if (SRST) begin
         for (int n = 0; n < `FD_LATENCY; n++) begin
            fd_pipe_q[n] <= 2'h0;
         end
      end else begin
         fd_pipe_q[0] <= {fd_raw[1], fd_raw[0]};
         for (int n = 1; n < `FD_LATENCY; n++) begin
            fd_pipe_q[n] <= fd_pipe_q[n-1];
         end
      end
   end
   assign THRESHOLD_ALARM_OUTPUT = fd_pipe_q[`FD_LATENCY-1];
   // Output buffer; its back-pressure stalls the oscillators, mixers, filters and output stage, but not fast detect
   assign out_w.a = out_s[0];
   assign out_w.b = out_s[1];
   ddc_skid2 #(.W(32), .D(2)) u_buf (
      .clk(CLK),
      .srst(SRST),
      .in_valid(1'b1),
      .in_ready(adv),
      .in_data(out_w),
      .out_valid(OUT_VALID),
      .out_ready(OUT_READY),
      .out_data(buf_out)
   );
   assign ADC_READY = adv;
   assign OUT_DATA = ddc_pkg::out_word_t'(buf_out);
   property p_fd_set;
      @(posedge CLK) disable iff (SRST) fd_raw[0] |-> ##4 THRESHOLD_ALARM_OUTPUT[0];
   endproperty
   a_fd_set: assert property (p_fd_set) else $error("Alarm A not raised after 4 cycles");
   property p_fd_low;
      @(posedge CLK) disable iff (SRST) !fd_raw[1] |-> ##4 !THRESHOLD_ALARM_OUTPUT[1];
   endproperty
   a_fd_low: assert property (p_fd_low) else $error("Alarm B high below threshold");
   property p_fixed_step;
      @(posedge CLK) disable iff (SRST) fixed_nco && adv && !restart[0] |=> acc_q == $past(acc_q) + `NCO_FS4;
   endproperty
   a_fixed_step: assert property (p_fixed_step) else $error("Fixed oscillator not at quarter rate");
   property p_nco_restart;
      @(posedge CLK) disable iff (SRST) restart[0] |=> acc_q == {$past(phase_off_q), 16'h0000};
   endproperty
   a_nco_restart: assert property (p_nco_restart) else $error("Oscillator not restarted at offset");
   property p_fir_once;
      @(posedge CLK) disable iff (SRST) restart[1] && !sync_ctl_q[`SC_FIR_EVERY] && !sc_write |=> !armed_q[1];
   endproperty
   a_fir_once: assert property (p_fir_once) else $error("Filter one-shot sync not disarmed");
   property p_fir_every;
      @(posedge CLK) disable iff (SRST) sync_evt && sync_ctl_q[`SC_FIR_EN] && sync_ctl_q[`SC_FIR_EVERY] |-> restart[1];
   endproperty
   a_fir_every: assert property (p_fir_every) else $error("Filter missed a sync event");
   property p_onco_restart;
      @(posedge CLK) disable iff (SRST) restart[2] |=> rot_q == ddc_pkg::ROT_0 ##1
         (rot_q == ddc_pkg::ROT_1 || !$past(adv) || $past(restart[2]));
   endproperty
   a_onco_restart: assert property (p_onco_restart) else $error("Output oscillator not restarted");
   property p_rot_q;
      @(posedge CLK) disable iff (SRST) adv && rot_q == ddc_pkg::ROT_1 |=> out_s[0] == -$past(fir_out[1]);
   endproperty
   a_rot_q: assert property (p_rot_q) else $error("Quarter-rate rotation wrong");
   property p_level;
      @(posedge CLK) disable iff (SRST) !sync_mode_q[`SM_EDGE_BIT] |-> sync_evt == $past(SYNC, 2);
   endproperty
   a_level: assert property (p_level) else $error("Level sync not followed");
   property p_dither_off;
      @(posedge CLK) disable iff (SRST) !dither_q[`DITH_PH_BIT] |-> ph_idx == acc_q[31:26];
   endproperty
   a_dither_off: assert property (p_dither_off) else $error("Phase dither active while disabled");
endmodule: ddc_fir_output_nco_path

// ===== verification/capture_model.sv
module capture_model (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic OUT_VALID,
   input wire ddc_pkg::out_word_t OUT_DATA,
   input wire logic stall,
   output logic OUT_READY
);
   timeunit 1ns;
   timeprecision 1ns;
   ddc_pkg::out_word_t got[$];
   initial OUT_READY = 1'h0;
   // Store each accepted word, hold off while stalled
   always @(posedge CLK) begin
      if (SRST === 1'h0 && OUT_VALID === 1'h1 && OUT_READY === 1'h1) begin
         got.push_back(OUT_DATA);
      end
      OUT_READY <= !stall && !SRST;
   end
endmodule: capture_model

// ===== verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'h0;
   logic SRST = 1'h1;
   logic signed [13:0] ADC_A = 14'h0000;
   logic signed [13:0] ADC_B = 14'h0000;
   logic SYNC = 1'h0;
   logic REG_WE = 1'h0;
   logic [7:0] REG_ADDR = 8'h00;
   logic [7:0] REG_WDATA = 8'h00;
   logic [7:0] REG_RDATA;
   logic ADC_READY;
   logic OUT_VALID;
   logic OUT_READY;
   ddc_pkg::out_word_t OUT_DATA;
   logic [1:0] THRESHOLD_ALARM_OUTPUT;
   logic stall = 1'h0;
   int errors = 0;
   int comparisons = 0;
   longint x_hp;
   longint x_ll;
   longint e;

   always #50 CLK = ~CLK;

   ddc_fir_output_nco_path ddc_fir_output_nco_path_i (.CLK(CLK), .SRST(SRST), .ADC_A(ADC_A), .ADC_B(ADC_B),
      .SYNC(SYNC), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .ADC_READY(ADC_READY), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
      .THRESHOLD_ALARM_OUTPUT(THRESHOLD_ALARM_OUTPUT));
   capture_model capture_model_i (.CLK(CLK), .SRST(SRST), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
      .stall(stall), .OUT_READY(OUT_READY));

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask: chk

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask: tick

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_WE <= 1'h1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WE <= 1'h0;
   endtask: reg_wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK);
      REG_ADDR <= a;
      @(posedge CLK);
      #1;
      chk($sformatf("reg %h", a), REG_RDATA, exp);
   endtask: rd_chk

   task automatic close_out;
      $display("Counts: errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask: close_out

   // Reset values, unmapped read, mode writes
   task automatic t_regs;
      rd_chk(8'h45, 8'h00);
      rd_chk(8'h50, 8'hb0);
      rd_chk(8'h51, 8'h06);
      rd_chk(8'h52, 8'h00);
      rd_chk(8'h55, 8'h40);
      rd_chk(8'h58, 8'h00);
      rd_chk(8'h5a, 8'h01);
      rd_chk(8'h00, 8'h00);
      reg_wr(8'h50, 8'ha0);
      rd_chk(8'h50, 8'ha0);
      reg_wr(8'h51, 8'h00);
      rd_chk(8'h51, 8'h00);
   endtask: t_regs

   // Both levels, boundaries, both signs, four cycle latency
   task automatic t_alarm;
      logic [13:0] val [8] = '{14'h1000, 14'h1001, 14'h3000, 14'h2fff, 14'h1c00, 14'h1c01, 14'h23ff, 14'h1500};
      logic ex [8] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
      for (int i = 0; i < 8; i++) begin
         reg_wr(8'h45, (i >= 4) ? 8'h01 : 8'h00);
         @(posedge CLK);
         ADC_A <= 14'h0000;
         ADC_B <= 14'h0000;
         tick(6);
         @(posedge CLK);
         ADC_A <= val[i];
         ADC_B <= -val[i];
         tick(3);
         chk("alarm early", THRESHOLD_ALARM_OUTPUT, 2'h0);
         tick(1);
         chk("alarm", THRESHOLD_ALARM_OUTPUT, {2{ex[i]}});
      end
   endtask: t_alarm

   // One-shot level sync, read-only status, then both edges
   task automatic t_sync;
      for (int a = 8'h52; a <= 8'h55; a++) begin
         reg_wr(8'(a), 8'h00);
      end
      reg_wr(8'h59, 8'h00);
      @(posedge CLK);
      ADC_A <= 14'h0400;
      ADC_B <= 14'h0400;
      reg_wr(8'h58, 8'h51);
      rd_chk(8'h58, 8'h51);
      rd_chk(8'h5b, 8'h1c);
      @(posedge CLK);
      SYNC <= 1'h1;
      tick(3);
      @(posedge CLK);
      SYNC <= 1'h0;
      tick(4);
      rd_chk(8'h5b, 8'h00);
      reg_wr(8'h5b, 8'hff);
      rd_chk(8'h5b, 8'h00);
      for (int f = 0; f < 2; f++) begin
         reg_wr(8'h59, {6'h00, 1'h1, f[0]});
         @(posedge CLK);
         SYNC <= !f[0];
         tick(4);
         reg_wr(8'h58, 8'h51);
         tick(4);
         rd_chk(8'h5b, 8'h1c);
         @(posedge CLK);
         SYNC <= f[0];
         tick(4);
         rd_chk(8'h5b, 8'h1c);
         @(posedge CLK);
         SYNC <= !f[0];
         tick(4);
         rd_chk(8'h5b, 8'h00);
      end
   endtask: t_sync

   // Dc input at zero tuning gives x, 0, -x, 0 on both channels
   task automatic t_shape(output longint x);
      ddc_pkg::out_word_t w[$];
      tick(100);
      capture_model_i.got.delete();
      tick(16);
      w = capture_model_i.got;
      chk("count", w.size(), 16);
      x = 0;
      for (int n = 0; n < 12; n++) begin
         chk("negate", w[n].a, -w[n + 2].a);
         chk("quadrature", w[n].a * w[n + 1].a, 32'h0);
         chk("channel", w[n].b, w[n].a);
         if (w[n].a > x) begin
            x = w[n].a;
         end
      end
      chk("nonzero", x > 0, 1'h1);
   endtask: t_shape

   // Full buffer refuses samples, held word is not lost
   task automatic t_stall;
      ddc_pkg::out_word_t hold;
      @(posedge CLK);
      stall <= 1'h1;
      tick(6);
      chk("valid", OUT_VALID, 1'h1);
      chk("adc ready", ADC_READY, 1'h0);
      hold = OUT_DATA;
      tick(3);
      chk("hold", OUT_DATA, hold);
      capture_model_i.got.delete();
      @(posedge CLK);
      stall <= 1'h0;
      tick(4);
      chk("adc ready", ADC_READY, 1'h1);
      chk("first", capture_model_i.got[0], hold);
   endtask: t_stall

   initial begin
      #(30000 * 100);
      errors++;
      close_out();
   end

   initial begin
      repeat (4) @(posedge CLK);
      SRST <= 1'h0;
      t_regs();
      t_alarm();
      t_sync();
      t_shape(x_hp);
      reg_wr(8'h5a, 8'h00);
      reg_wr(8'h50, 8'hb0);
      t_shape(x_ll);
      e = x_ll * 253769 / 244704;
      chk("gain", (x_hp - e <= 3) && (e - x_hp <= 3), 1'h1);
      t_stall();
      close_out();
   end
endmodule: testbench
